//--- tb/testbench.sv
// testbench: self-checking bench for the key and margin command sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("Error at %0t: got %h want %h", $time, (g), (e)); \
    end \
end
module testbench;
    typedef struct packed {
        logic [7:0]  code;
        logic [1:0]  blk;
        logic [15:0] lvl;
        logic [2:0]  idx;
        logic        sp;
        logic        err;
        logic [1:0]  pf;
        logic [1:0]  ee;
    } fkm_row_t;
    logic        core_clk, rstn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pflash_read_margin, eeprom_read_margin;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, command_complete_flag, secured;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    fkm_seq u_dut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .command_complete_flag,
        .secured, .pflash_read_margin, .eeprom_read_margin);
    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out;
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one write; handshakes sampled at the rising edge, released right after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic hb;
        logic [1:0] r;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            hb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
        `CHK(r, er)
    endtask
    // one read; data taken at the edge where rvalid is sampled high
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
        logic hr;
        logic [1:0] r;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            hr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
        `CHK(r, er)
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
    endtask
    // load n command words, launch at index li, return the error bit
    task automatic run(input logic [4:0][15:0] w, input int n, input logic [2:0] li, output logic e);
        logic [31:0] s;
        wr(fkm_pkg::OFF_STAT, 32'h20);
        for (int i = 0; i < n; i++) begin
            wr(fkm_pkg::OFF_INDEX, 32'(i));
            wr(fkm_pkg::OFF_DATA, {16'h0, w[i]});
        end
        wr(fkm_pkg::OFF_INDEX, {29'h0, li});
        wr(fkm_pkg::OFF_STAT, 32'h80);
        @(negedge core_clk);
        `CHK(command_complete_flag, 1'b0)
        wr(fkm_pkg::OFF_STAT, 32'h80); // relaunch attempt lands while still busy
        for (int t = 0; t < 50 && command_complete_flag !== 1'b1; t++) @(negedge core_clk);
        rd(fkm_pkg::OFF_STAT, s);
        `CHK(s[7], 1'b1)
        e = s[5];
        rd(fkm_pkg::OFF_INDEX, s);
        `CHK(s[2:0], li)
    endtask
    task automatic t_reset_values;
        logic [31:0] d;
        rd(fkm_pkg::OFF_SEC, d);
        `CHK(d[9:0], 10'h203)
        rd(fkm_pkg::OFF_MARGIN, d);
        `CHK(d, 32'h0)
        rd(8'h40, d, fkm_pkg::RESP_SLVERR);
        `CHK(d, 32'h0)
        wr(8'h44, 32'h0, fkm_pkg::RESP_SLVERR);
    endtask
    task automatic load_keys(input logic [4:0][15:0] w);
        for (int i = 0; i < 4; i++) wr(fkm_pkg::OFF_KEY0 + 8'(4 * i), {16'h0, w[i + 1]});
    endtask
    task automatic t_key;
        logic [4:0][15:0] w, b;
        logic e;
        w = {16'hA5C3, 16'hA5C2, 16'hA5C1, 16'hA5C0, fkm_pkg::CMD_KEY, 8'h00};
        load_keys(w);
        for (int k = 0; k < 4; k++) if (k != 2) begin
            wr(fkm_pkg::OFF_SEC, 32'(k));
            run(w, 5, fkm_pkg::IDX_KEY, e);
            `CHK(e, 1'b1)
            `CHK(secured, 1'b1)
        end
        wr(fkm_pkg::OFF_SEC, 32'h2);
        run(w, 5, 3'h3, e);
        `CHK(e, 1'b1)
        run(w, 5, fkm_pkg::IDX_KEY, e);
        `CHK(e, 1'b0)
        `CHK(secured, 1'b0)
        do_reset();
        load_keys(w);
        wr(fkm_pkg::OFF_SEC, 32'h2);
        b = {w[4:3], w[1], w[2], w[0]};
        run(b, 5, fkm_pkg::IDX_KEY, e);
        `CHK(e, 1'b1)
        run(w, 5, fkm_pkg::IDX_KEY, e);
        `CHK(e, 1'b1)
        `CHK(secured, 1'b1)
    endtask
    task automatic t_margin;
        fkm_row_t rows [10];
        fkm_row_t r;
        logic [31:0] d;
        logic e;
        rows = '{
            '{8'h0D, 2'h3, 16'h1, 3'h1, 1'b0, 1'b1, 2'h0, 2'h0},
            '{8'h0D, 2'h0, 16'h1, 3'h1, 1'b1, 1'b0, 2'h0, 2'h1},
            '{8'h0D, 2'h3, 16'h2, 3'h1, 1'b1, 1'b0, 2'h2, 2'h2},
            '{8'h0D, 2'h0, 16'h0, 3'h1, 1'b1, 1'b0, 2'h2, 2'h0},
            '{8'h0D, 2'h1, 16'h1, 3'h1, 1'b1, 1'b1, 2'h2, 2'h0},
            '{8'h0D, 2'h2, 16'h1, 3'h1, 1'b1, 1'b1, 2'h2, 2'h0},
            '{8'h0D, 2'h3, 16'h3, 3'h1, 1'b1, 1'b1, 2'h2, 2'h0},
            '{8'h0D, 2'h3, 16'h1, 3'h0, 1'b1, 1'b1, 2'h2, 2'h0},
            '{8'h0E, 2'h3, 16'h1, 3'h1, 1'b0, 1'b1, 2'h2, 2'h0},
            '{8'h0E, 2'h3, 16'h1, 3'h1, 1'b1, 1'b0, 2'h1, 2'h1}};
        do_reset();
        foreach (rows[i]) begin
            r = rows[i];
            wr(fkm_pkg::OFF_SEC, {23'h0, r.sp, 8'h03});
            run({48'h0, r.lvl, r.code, 6'h0, r.blk}, 2, r.idx, e);
            `CHK(e, r.err)
            `CHK(pflash_read_margin, r.pf)
            `CHK(eeprom_read_margin, r.ee)
            rd(fkm_pkg::OFF_MARGIN, d);
            `CHK(d[5:0], {r.ee, 2'h0, r.pf})
        end
    endtask
    // main sequence
    initial begin
        rstn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset_values();
        t_key();
        t_margin();
        close_out();
    end
endmodule

//--- verilog/fkm_pkg.sv
// fkm_pkg: constants and types of the flash key and margin command sequencer
// Behaviour
// - key command checks key enable first; disabled sets access error, no compare
// - key access enabled only when the two-bit enable field equals 10
// - key word 0 compares with stored word at 0x3_FF00, others in order
// - all four key words matching releases the security state
// - mismatch keeps security, sets access error, blocks later attempts until reset
// - command complete flag sets when key verification ends, any outcome
// - key command with index other than 100 at launch sets access error
// - user margin command applies level to the target, then sets complete flag
// - eeprom level affects eeprom reads only; pflash level affects both arrays
// - level 0x0000 normal, 0x0001 erased margin, 0x0002 programmed margin, others invalid
// - user margin command with index other than 001 sets access error
// - user margin command in a mode where unavailable sets access error
// - invalid block code or level on user margin sets access error
// - field margin command accepted only in special mode, sets level for both arrays
// - block code 00 is eeprom, 11 is pflash, 01 and 10 are invalid
package fkm_pkg;
    // register byte offsets
    localparam logic [7:0]  OFF_INDEX    = 8'h00;
    localparam logic [7:0]  OFF_DATA     = 8'h04;
    localparam logic [7:0]  OFF_STAT     = 8'h08;
    localparam logic [7:0]  OFF_SEC      = 8'h0C;
    localparam logic [7:0]  OFF_KEY0     = 8'h10;
    localparam logic [7:0]  OFF_KEY3     = 8'h1C;
    localparam logic [7:0]  OFF_MARGIN   = 8'h20;
    // status and security field positions
    localparam int          STAT_COMMAND_COMPLETE_FLAG    = 7;
    localparam int          STAT_ACCESS_ERROR_FLAG  = 5;
    localparam int          STAT_PROTECTION_VIOLATION_FLAG  = 4;
    localparam int          SEC_SPECIAL  = 8;
    localparam int          SEC_SECURED  = 9;
    localparam int          MARG_EE_LSB  = 4;
    // command codes and launch indices
    localparam logic [7:0]  CMD_KEY      = 8'h0C;
    localparam logic [7:0]  CMD_UMARG    = 8'h0D;
    localparam logic [7:0]  CMD_FMARG    = 8'h0E;
    localparam logic [2:0]  IDX_KEY      = 3'h4;
    localparam logic [2:0]  IDX_MARG     = 3'h1;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_FIELD_ON     = 2'h2;
    localparam logic [1:0]  SEL_EE       = 2'h0;
    localparam logic [1:0]  SEL_PF       = 2'h3;
    localparam logic [15:0] LVL_MAX      = 16'h0002;
    // flash address of comparison key word 0
    localparam logic [17:0] KEY_ADDR     = 18'h3FF00;
    // reset values: erased configuration field
    localparam logic [15:0] KEY_RST      = 16'hFFFF;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_FIELD_RST    = 2'h3;
    // execution time of one command
    localparam int          CLK_NS       = 4;
    localparam int          EXEC_NS      = 16;
    localparam logic [2:0]  EXEC_CYC     = 3'((EXEC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } fkm_state_t;
endpackage

//--- verilog/fkm_seq.sv
// fkm_seq: key verification and margin command sequencer with AXI4-Lite slave
`timescale 1ns/100ps
module fkm_seq (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             command_complete_flag,
    output logic             secured,
    output logic [1:0]       pflash_read_margin,
    output logic [1:0]       eeprom_read_margin
);
    typedef struct packed {
        fkm_pkg::fkm_state_t st;
        logic [2:0]          cnt;
        logic [2:0]          command_word_index;
        logic [2:0]          launch_idx;
        logic [7:0][15:0]    command_object_words;
        logic                command_complete_flag;
        logic                access_error_flag;
        logic                protection_violation_flag;
        logic [1:0]          backdoor_key_enable_field;
        logic                special;
        logic                secured;
        logic                key_fail;
        logic [3:0][15:0]    key;
        logic [1:0]          pf_marg;
        logic [1:0]          ee_marg;
        logic                aw_got;
        logic [7:0]          awaddr;
        logic                w_got;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } fkm_regs_t;

    fkm_regs_t st_ff;
    fkm_regs_t nxt_st;

    logic        wr_fire;
    logic [7:0]  wr_addr;
    logic        launch;
    logic        fin;
    logic [7:0]  code;
    logic [1:0]  sel;
    logic [15:0] lvl;
    logic        sel_ok;
    logic        lvl_ok;
    logic        key_match;
    logic        um_avail;
    logic        key_err;
    logic        um_err;
    logic        fm_err;

    // byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
        merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // pending write and launch detection
    assign wr_fire = st_ff.aw_got && st_ff.w_got;
    assign wr_addr = {st_ff.awaddr[7:2], 2'b00};
    assign launch  = wr_fire && (wr_addr == fkm_pkg::OFF_STAT) && st_ff.wstrb[0]
                     && st_ff.wdata[fkm_pkg::STAT_COMMAND_COMPLETE_FLAG] && st_ff.command_complete_flag
                     && (st_ff.st == fkm_pkg::ST_IDLE);

    // command decode from the loaded command words
    assign fin       = (st_ff.st == fkm_pkg::ST_EXEC) && (st_ff.cnt == 3'h0);
    assign code      = st_ff.command_object_words[0][15:8];
    assign sel       = st_ff.command_object_words[0][1:0];
    assign lvl       = st_ff.command_object_words[1];
    assign sel_ok    = (sel == fkm_pkg::SEL_EE) || (sel == fkm_pkg::SEL_PF);
    assign lvl_ok    = (lvl <= fkm_pkg::LVL_MAX);
    assign key_match = (st_ff.command_object_words[1] == st_ff.key[0])
                    && (st_ff.command_object_words[2] == st_ff.key[1])
                    && (st_ff.command_object_words[3] == st_ff.key[2])
                    && (st_ff.command_object_words[4] == st_ff.key[3]);
    // user margin is unavailable while secured outside special mode
    assign um_avail  = st_ff.special || !st_ff.secured;
    assign key_err   = (st_ff.launch_idx != fkm_pkg::IDX_KEY)
                    || (st_ff.backdoor_key_enable_field != fkm_pkg::BACKDOOR_KEY_ENABLE_FIELD_ON)
                    || st_ff.key_fail;
    assign um_err    = (st_ff.launch_idx != fkm_pkg::IDX_MARG) || !um_avail || !sel_ok || !lvl_ok;
    assign fm_err    = (st_ff.launch_idx != fkm_pkg::IDX_MARG) || !st_ff.special || !sel_ok || !lvl_ok;

    // next-state logic: bus slave, register writes, command execution
    always_comb begin
        nxt_st = st_ff;
        // write channels
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = fkm_pkg::RESP_OKAY;
            case (wr_addr)
                fkm_pkg::OFF_INDEX: begin
                    if (st_ff.command_complete_flag && st_ff.wstrb[0]) begin
                        nxt_st.command_word_index = st_ff.wdata[2:0];
                    end
                end
                fkm_pkg::OFF_DATA: begin
                    if (st_ff.command_complete_flag) begin
                        nxt_st.command_object_words[st_ff.command_word_index] =
                            merge16(st_ff.command_object_words[st_ff.command_word_index],
                                    st_ff.wdata[15:0], st_ff.wstrb[1:0]);
                    end
                end
                fkm_pkg::OFF_STAT: begin
                    if (st_ff.wstrb[0]) begin
                        if (st_ff.wdata[fkm_pkg::STAT_ACCESS_ERROR_FLAG]) begin
                            nxt_st.access_error_flag = 1'b0;
                        end
                        if (st_ff.wdata[fkm_pkg::STAT_PROTECTION_VIOLATION_FLAG]) begin
                            nxt_st.protection_violation_flag = 1'b0;
                        end
                    end
                    if (launch) begin
                        nxt_st.command_complete_flag = 1'b0;
                        nxt_st.launch_idx            = st_ff.command_word_index;
                        nxt_st.st                    = fkm_pkg::ST_EXEC;
                        nxt_st.cnt                   = fkm_pkg::EXEC_CYC - 3'h1;
                    end
                end
                fkm_pkg::OFF_SEC: begin
                    if (st_ff.command_complete_flag) begin
                        if (st_ff.wstrb[0]) begin
                            nxt_st.backdoor_key_enable_field = st_ff.wdata[1:0];
                        end
                        if (st_ff.wstrb[1]) begin
                            nxt_st.special = st_ff.wdata[fkm_pkg::SEC_SPECIAL];
                        end
                    end
                end
                fkm_pkg::OFF_MARGIN: begin
                    nxt_st.bresp = fkm_pkg::RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    if (wr_addr >= fkm_pkg::OFF_KEY0 && wr_addr <= fkm_pkg::OFF_KEY3) begin
                        nxt_st.key[wr_addr[3:2]] = merge16(st_ff.key[wr_addr[3:2]], st_ff.wdata[15:0],
                                                           st_ff.wstrb[1:0]);
                    end else begin
                        nxt_st.bresp = fkm_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        // read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = fkm_pkg::RESP_OKAY;
            nxt_st.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                fkm_pkg::OFF_INDEX:  nxt_st.rdata[2:0] = st_ff.command_word_index;
                fkm_pkg::OFF_DATA:   nxt_st.rdata[15:0] = st_ff.command_object_words[st_ff.command_word_index];
                fkm_pkg::OFF_STAT: begin
                    nxt_st.rdata[fkm_pkg::STAT_COMMAND_COMPLETE_FLAG]   = st_ff.command_complete_flag;
                    nxt_st.rdata[fkm_pkg::STAT_ACCESS_ERROR_FLAG] = st_ff.access_error_flag;
                    nxt_st.rdata[fkm_pkg::STAT_PROTECTION_VIOLATION_FLAG] = st_ff.protection_violation_flag;
                end
                fkm_pkg::OFF_SEC: begin
                    nxt_st.rdata[1:0]                  = st_ff.backdoor_key_enable_field;
                    nxt_st.rdata[fkm_pkg::SEC_SPECIAL] = st_ff.special;
                    nxt_st.rdata[fkm_pkg::SEC_SECURED] = st_ff.secured;
                end
                fkm_pkg::OFF_MARGIN: begin
                    nxt_st.rdata[1:0] = st_ff.pf_marg;
                    nxt_st.rdata[fkm_pkg::MARG_EE_LSB +: 2] = st_ff.ee_marg;
                end
                default: begin
                    if (s_axi_araddr >= fkm_pkg::OFF_KEY0 && s_axi_araddr <= fkm_pkg::OFF_KEY3 + 8'h03) begin
                        nxt_st.rdata[15:0] = st_ff.key[s_axi_araddr[3:2]];
                    end else begin
                        nxt_st.rresp = fkm_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        // command execution; error sets come last so they win over a clear
        if (st_ff.st == fkm_pkg::ST_EXEC) begin
            if (st_ff.cnt != 3'h0) begin
                nxt_st.cnt = st_ff.cnt - 3'h1;
            end else begin
                nxt_st.st                    = fkm_pkg::ST_IDLE;
                nxt_st.command_complete_flag = 1'b1;
                case (code)
                    fkm_pkg::CMD_KEY: begin
                        if (key_err) begin
                            nxt_st.access_error_flag = 1'b1;
                        end else if (key_match) begin
                            nxt_st.secured = 1'b0;
                        end else begin
                            nxt_st.access_error_flag = 1'b1;
                            nxt_st.key_fail          = 1'b1;
                        end
                    end
                    fkm_pkg::CMD_UMARG, fkm_pkg::CMD_FMARG: begin
                        if ((code == fkm_pkg::CMD_UMARG) ? um_err : fm_err) begin
                            nxt_st.access_error_flag = 1'b1;
                        end else begin
                            nxt_st.ee_marg = lvl[1:0];
                            if (sel == fkm_pkg::SEL_PF || code == fkm_pkg::CMD_FMARG) begin
                                nxt_st.pf_marg = lvl[1:0];
                            end
                        end
                    end
                    default: nxt_st.access_error_flag = 1'b1;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff                           <= '0;
            st_ff.st                        <= fkm_pkg::ST_IDLE;
            st_ff.command_complete_flag     <= 1'b1;
            st_ff.backdoor_key_enable_field <= fkm_pkg::BACKDOOR_KEY_ENABLE_FIELD_RST;
            st_ff.secured                   <= 1'b1;
            st_ff.key                       <= {4{fkm_pkg::KEY_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // bus handshakes and outputs
    assign s_axi_awready         = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready          = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready         = !st_ff.rvalid;
    assign s_axi_bvalid          = st_ff.bvalid;
    assign s_axi_bresp           = st_ff.bresp;
    assign s_axi_rvalid          = st_ff.rvalid;
    assign s_axi_rdata           = st_ff.rdata;
    assign s_axi_rresp           = st_ff.rresp;
    assign command_complete_flag = st_ff.command_complete_flag;
    assign secured               = st_ff.secured;
    assign pflash_read_margin    = st_ff.pf_marg;
    assign eeprom_read_margin    = st_ff.ee_marg;

    // checks on command behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // key verification checks
    AST_KEY_DISABLED: assert property (
        fin && code == fkm_pkg::CMD_KEY && st_ff.backdoor_key_enable_field != fkm_pkg::BACKDOOR_KEY_ENABLE_FIELD_ON
        |=> st_ff.access_error_flag && $stable(st_ff.secured))
        else $error("key cmd ran while disabled");

    AST_BACKDOOR_KEY_ENABLE_FIELD_ONLY_10: assert property (
        $fell(st_ff.secured) |-> $past(st_ff.backdoor_key_enable_field) == fkm_pkg::BACKDOOR_KEY_ENABLE_FIELD_ON)
        else $error("release without enable 10");

    AST_KEY_RELEASE: assert property (
        fin && code == fkm_pkg::CMD_KEY && !key_err
        && st_ff.command_object_words[1] == st_ff.key[0] && key_match |=> !st_ff.secured)
        else $error("match kept security");

    AST_KEY_FAIL_STICKY: assert property (
        st_ff.key_fail |=> st_ff.key_fail && !($fell(st_ff.secured)))
        else $error("key failure lost");

    AST_KEY_FAIL_ERR: assert property (
        fin && code == fkm_pkg::CMD_KEY && st_ff.key_fail |=> st_ff.access_error_flag && st_ff.secured)
        else $error("key cmd ran after a failure");

    AST_KEY_INDEX: assert property (
        fin && code == fkm_pkg::CMD_KEY && st_ff.launch_idx != fkm_pkg::IDX_KEY
        |=> st_ff.access_error_flag && $stable(st_ff.secured))
        else $error("bad key index accepted");

    // completion and sequencing checks
    AST_DONE_TIMING: assert property (
        launch |=> !st_ff.command_complete_flag [*4] ##1 st_ff.command_complete_flag)
        else $error("complete flag timing wrong");

    AST_CMD_DONE: assert property (
        fin |=> st_ff.command_complete_flag && st_ff.st == fkm_pkg::ST_IDLE)
        else $error("command did not complete");

    AST_NO_RELAUNCH: assert property (
        st_ff.st == fkm_pkg::ST_EXEC && st_ff.cnt != 3'h0
        |=> st_ff.st == fkm_pkg::ST_EXEC && !st_ff.command_complete_flag && $stable(st_ff.launch_idx))
        else $error("launch taken while busy");

    // margin command checks
    AST_UM_INDEX: assert property (
        fin && code == fkm_pkg::CMD_UMARG && st_ff.launch_idx != fkm_pkg::IDX_MARG
        |=> st_ff.access_error_flag && $stable(st_ff.ee_marg))
        else $error("bad margin index accepted");

    AST_UM_MODE: assert property (
        fin && code == fkm_pkg::CMD_UMARG && st_ff.secured && !st_ff.special
        |=> st_ff.access_error_flag)
        else $error("margin cmd in locked mode");

    AST_UM_BAD: assert property (
        fin && code == fkm_pkg::CMD_UMARG && (sel == 2'h1 || sel == 2'h2 || lvl > fkm_pkg::LVL_MAX)
        |=> st_ff.access_error_flag && $stable(st_ff.pf_marg))
        else $error("bad margin args accepted");

    AST_PF_BOTH: assert property (
        fin && code == fkm_pkg::CMD_UMARG && !um_err && sel == fkm_pkg::SEL_PF
        |=> {14'h0, st_ff.pf_marg} == $past(lvl) && st_ff.ee_marg == st_ff.pf_marg)
        else $error("pflash level not on both");

    AST_EE_ONLY: assert property (
        fin && code == fkm_pkg::CMD_UMARG && !um_err && sel == fkm_pkg::SEL_EE
        |=> $stable(st_ff.pf_marg) && {14'h0, st_ff.ee_marg} == $past(lvl))
        else $error("eeprom level leaked");

    AST_FM_SPECIAL: assert property (
        fin && code == fkm_pkg::CMD_FMARG && !st_ff.special
        |=> st_ff.access_error_flag && $stable(st_ff.pf_marg))
        else $error("field margin outside special");

    COV_KEY_OK: cover property (fin && code == fkm_pkg::CMD_KEY && !key_err && key_match);
    COV_KEY_BAD: cover property (fin && code == fkm_pkg::CMD_KEY && !key_err && !key_match);
    COV_UM_PF: cover property (fin && code == fkm_pkg::CMD_UMARG && !um_err && sel == 2'h3);
    COV_FM_OK: cover property (fin && code == fkm_pkg::CMD_FMARG && !fm_err);
endmodule
